//--- common/drive_disable_pkg.sv
// Constants, types and register map of the drive disable controller.
package drive_disable_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_TMO = 8'h0C;
  localparam logic [7:0] OFS_CAUSE = 8'h10;
  localparam logic [7:0] OFS_CAP = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_MSTAT = 8'h1C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DIS_BIT = 1;
  localparam int CTRL_CLR_BIT = 2;
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_EMERG_BIT = 1;
  localparam int ST_BRAKE_BIT = 2;
  localparam int ST_DB_BIT = 3;
  localparam int ST_CS_BIT = 4;
  localparam int MS_HOMED_BIT = 0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_IMMED = 2'h0;
  localparam logic [1:0] MODE_DB = 2'h1;
  localparam logic [1:0] MODE_CS_DIS = 2'h2;
  localparam logic [1:0] MODE_CS_DB = 2'h3;
  localparam int TMO_W = 17;
  localparam logic [16:0] TMO_MAX_MS = 17'h1D4C0;
  localparam logic [16:0] TMO_RESET_MS = 17'h003E8;
  localparam logic [7:0] CAP_RESET = 8'h3F;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TMO_UNIT_NS = 1000000;
  localparam int CYC_PER_MS_DEF = TMO_UNIT_NS / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    S_OFF = 4'h1,
    S_ON = 4'h2,
    S_STOP = 4'h4,
    S_DBRAKE = 4'h8
  } drv_state_t;
  typedef struct packed {
    logic supply_dis_req;
    logic fieldbus_dis_req;
    logic input_stop_req;
    logic init_busy;
    logic inrush_open;
    logic hw_enable_low;
    logic fault_present;
  } cause_in_t;
endpackage

//--- design/drive_disable_control.sv
// Disable reaction, direction and emergency timeout logic of one axis.
`timescale 1ns/1ps
`default_nettype none
module drive_disable_control
  import drive_disable_pkg::*;
#(
  parameter int CUR_W = 16,
  parameter int POS_W = 32,
  parameter int VEL_W = 24,
  parameter bit ANALOG_VARIANT = 1'b0,
  parameter logic [7:0] CAPABILITY = CAP_RESET,
  parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Disable requests and feedback from the drive.
  input wire cause_in_t cause_in,
  input wire logic brake_configured,
  input wire logic home_done,
  input wire logic signed [VEL_W-1:0] velocity_feedback,
  input wire logic [VEL_W-1:0] stop_velocity_threshold,
  input wire logic signed [CUR_W-1:0] current_cmd_in,
  input wire logic signed [POS_W-1:0] position_fb_in,
  // Power stage, brake and loop controls.
  output logic drive_enable,
  output logic pwm_active,
  output logic dyn_brake_on,
  output logic cs_ramp_req,
  output logic brake_close,
  output logic signed [CUR_W-1:0] current_cmd_out,
  output logic signed [POS_W-1:0] position_fb_out
);

  drv_state_t state_q, state_d;
  logic sw_en_q, sw_en_d;
  logic dir_q, dir_d;
  logic [1:0] mode_q, mode_d;
  logic [TMO_W-1:0] tmo_q, tmo_d;
  logic homed_q, homed_d;
  logic emerg_q, emerg_d;
  logic tmo_run_q, tmo_run_d;
  logic [16:0] pre_q, pre_d;
  logic [TMO_W-1:0] ms_q, ms_d;
  logic brake_q, brake_d;
  logic [31:0] rdata_q, rdata_d;
  logic signed [CUR_W-1:0] cur_q, cur_d;
  logic signed [POS_W-1:0] pos_q, pos_d;

  logic wr, rd_setup, aligned, mapped, is_off, standstill, expired;
  logic refused;
  logic [7:0] cause_raw, cause_word;
  logic [VEL_W-1:0] vel_mag;
  drv_state_t target;

  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign aligned = (paddr[1:0] == 2'h0);
  assign mapped = aligned & (paddr <= OFS_MSTAT);
  assign is_off = state_q[0] | state_q[3];

  // Causes are sampled raw and filtered by what this product supports.
  assign cause_raw = {cause_in.supply_dis_req, cause_in.fieldbus_dis_req,
                      cause_in.input_stop_req, cause_in.init_busy,
                      cause_in.inrush_open, cause_in.hw_enable_low,
                      cause_in.fault_present | emerg_q, ~sw_en_q};
  assign cause_word = cause_raw & CAPABILITY;

  assign vel_mag = velocity_feedback[VEL_W-1] ?
                   VEL_W'(-velocity_feedback) : VEL_W'(velocity_feedback);
  assign standstill = (vel_mag < stop_velocity_threshold);
  assign expired = tmo_run_q & (ms_q == tmo_q);
  assign target = mode_q[0] ? S_DBRAKE : S_OFF;

  // Writes that the current state, the timeout range or a read-only word forbids are refused with an error.
  always_comb begin
    refused = 1'b0;
    if (wr && (paddr == OFS_DIR || paddr == OFS_MODE) && !is_off) begin
      refused = 1'b1;
    end
    if (wr && paddr == OFS_TMO && pwdata[31:0] > 32'(TMO_MAX_MS)) begin
      refused = 1'b1;
    end
    if (wr && (paddr == OFS_CAUSE || paddr == OFS_CAP)) begin
      refused = 1'b1;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & (~mapped | refused);
  assign prdata = rdata_q;

  always_comb begin
    state_d = state_q;
    sw_en_d = sw_en_q;
    dir_d = dir_q;
    mode_d = mode_q;
    tmo_d = tmo_q;
    homed_d = homed_q;
    emerg_d = emerg_q;
    tmo_run_d = tmo_run_q;
    pre_d = pre_q;
    ms_d = ms_q;
    rdata_d = rdata_q;

    // Register writes.
    if (wr && mapped && !refused) begin
      case (paddr)
        OFS_CTRL: begin
          if (pwdata[CTRL_EN_BIT]) begin
            sw_en_d = 1'b1;
          end
          if (pwdata[CTRL_DIS_BIT]) begin
            sw_en_d = 1'b0;
          end
          if (pwdata[CTRL_CLR_BIT]) begin
            emerg_d = 1'b0;
          end
        end
        OFS_DIR: dir_d = pwdata[0];
        OFS_MODE: mode_d = pwdata[1:0];
        OFS_TMO: tmo_d = pwdata[TMO_W-1:0];
        default: ;
      endcase
    end

    // Homed is set by the motion side and lost on a direction change.
    if (home_done) begin
      homed_d = 1'b1;
    end
    if (dir_d != dir_q) begin
      homed_d = 1'b0;
    end

    // Millisecond timebase of the emergency timeout.
    if (tmo_run_q) begin
      if (pre_q == 17'(CYC_PER_MS - 1)) begin
        pre_d = 17'h00000;
        ms_d = ms_q + 17'h00001;
      end else begin
        pre_d = pre_q + 17'h00001;
      end
    end

    case (state_q)
      S_ON: begin
        if (cause_word != 8'h00) begin
          case (mode_q)
            MODE_IMMED: state_d = S_OFF;
            MODE_DB: state_d = S_DBRAKE;
            default: state_d = S_STOP;
          endcase
          tmo_run_d = (tmo_q != 17'h00000);
          pre_d = 17'h00000;
          ms_d = 17'h00000;
        end
      end
      S_STOP: begin
        if (expired) begin
          emerg_d = 1'b1;
          state_d = target;
          tmo_run_d = 1'b0;
        end else if (standstill) begin
          state_d = target;
          tmo_run_d = 1'b0;
        end
      end
      S_OFF, S_DBRAKE: begin
        tmo_run_d = 1'b0;
        if (cause_word == 8'h00) begin
          state_d = S_ON;
        end
      end
      default: state_d = S_OFF;
    endcase

    // Read data is captured in the setup phase.
    if (rd_setup) begin
      rdata_d = 32'h00000000;
      case (paddr)
        OFS_DIR: rdata_d[0] = dir_q;
        OFS_MODE: rdata_d[1:0] = mode_q;
        OFS_TMO: rdata_d[TMO_W-1:0] = tmo_q;
        OFS_CAUSE: rdata_d[7:0] = cause_word;
        OFS_CAP: rdata_d[7:0] = CAPABILITY;
        OFS_STAT: begin
          rdata_d[ST_ACTIVE_BIT] = drive_enable;
          rdata_d[ST_EMERG_BIT] = emerg_q;
          rdata_d[ST_BRAKE_BIT] = brake_q;
          rdata_d[ST_DB_BIT] = state_q[3];
          rdata_d[ST_CS_BIT] = state_q[2];
        end
        OFS_MSTAT: rdata_d[MS_HOMED_BIT] = homed_q;
        default: ;
      endcase
    end
  end

  // Brake stays closed from low speed until the drive is enabled again.
  always_comb begin
    brake_d = brake_configured & ~state_q[1] & (brake_q | standstill);
    cur_d = dir_q ? CUR_W'(-current_cmd_in) : current_cmd_in;
    pos_d = dir_q ? POS_W'(-position_fb_in) : position_fb_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_OFF;
      sw_en_q <= ANALOG_VARIANT;
      dir_q <= 1'b0;
      mode_q <= MODE_RESET;
      tmo_q <= TMO_RESET_MS;
      homed_q <= 1'b0;
      emerg_q <= 1'b0;
      tmo_run_q <= 1'b0;
      pre_q <= 17'h00000;
      ms_q <= 17'h00000;
      brake_q <= 1'b0;
      rdata_q <= 32'h00000000;
      cur_q <= '0;
      pos_q <= '0;
    end else begin
      state_q <= state_d;
      sw_en_q <= sw_en_d;
      dir_q <= dir_d;
      mode_q <= mode_d;
      tmo_q <= tmo_d;
      homed_q <= homed_d;
      emerg_q <= emerg_d;
      tmo_run_q <= tmo_run_d;
      pre_q <= pre_d;
      ms_q <= ms_d;
      brake_q <= brake_d;
      rdata_q <= rdata_d;
      cur_q <= cur_d;
      pos_q <= pos_d;
    end
  end

  assign drive_enable = state_q[1] & (cause_word == 8'h00);
  assign pwm_active = state_q[1] | state_q[2] | state_q[3];
  assign dyn_brake_on = state_q[3];
  assign cs_ramp_req = state_q[2];
  assign brake_close = brake_q;
  assign current_cmd_out = cur_q;
  assign position_fb_out = pos_q;

  a_dir_refused: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_DIR && !is_off |=> $stable(dir_q))
    else $error("direction changed while enabled");
  a_homed_lost: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(dir_q) |-> !homed_q)
    else $error("homed kept after direction change");
  a_mode_refused: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_MODE && !is_off |=> $stable(mode_q))
    else $error("reaction selector changed while enabled");
  a_sw_disable: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_CTRL && pwdata[CTRL_DIS_BIT]
    |=> !sw_en_q ##1 !drive_enable)
    else $error("software disable not taken");
  a_immediate_off: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_ON && cause_word != 8'h00 && mode_q == MODE_IMMED
    |=> state_q == S_OFF && !pwm_active)
    else $error("immediate disable missed");
  a_dbrake_hold: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_DBRAKE && cause_word != 8'h00
    |=> dyn_brake_on && pwm_active && !drive_enable)
    else $error("dynamic brake not held");
  a_stop_end: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_STOP && standstill && mode_q == MODE_CS_DIS
    |=> state_q == S_OFF)
    else $error("controlled stop did not disable");
  a_timeout_fault: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_STOP && expired |=> emerg_q && state_q != S_STOP)
    else $error("emergency timeout not handled");
  a_enable_clean: assert property (@(posedge pclk) disable iff (!presetn)
    drive_enable |-> cause_word == 8'h00 && !cs_ramp_req)
    else $error("power stage enabled with a cause");
  a_cur_invert: assert property (@(posedge pclk) disable iff (!presetn)
    dir_q && $stable(dir_q)
    |=> current_cmd_out == CUR_W'(-$past(current_cmd_in)))
    else $error("current command not inverted");
  a_pos_invert: assert property (@(posedge pclk) disable iff (!presetn)
    dir_q && $stable(dir_q)
    |=> position_fb_out == POS_W'(-$past(position_fb_in)))
    else $error("position feedback not inverted");

  // Register writes that are allowed must land, and nothing else may move.
  a_dir_taken: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_DIR && is_off |=> dir_q == $past(pwdata[0]))
    else $error("direction write lost while disabled");
  a_dir_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !wr |=> $stable(dir_q))
    else $error("direction changed without a write");
  a_mode_taken: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_MODE && is_off |=> mode_q == $past(pwdata[1:0]))
    else $error("reaction selector write lost");
  a_mode_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !wr |=> $stable(mode_q))
    else $error("reaction selector changed without a write");
  a_tmo_refused: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_TMO && pwdata > 32'(TMO_MAX_MS)
    |=> $stable(tmo_q))
    else $error("timeout above range accepted");
  a_sw_enable: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_CTRL && pwdata[CTRL_EN_BIT] && !pwdata[CTRL_DIS_BIT]
    |=> sw_en_q)
    else $error("software enable not taken");
  a_ro_refused: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == OFS_CAUSE || paddr == OFS_CAP) |-> pslverr)
    else $error("write to read-only word not refused");

  // Reaction selector values 0 and 1 must lead to their own states, values 2 and 3 both to S_STOP.
  a_leave_on: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_ON && cause_word != 8'h00 |=> state_q != S_ON)
    else $error("disable cause ignored");
  a_db_entry: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_ON && cause_word != 8'h00 && mode_q == MODE_DB
    |=> state_q == S_DBRAKE && pwm_active)
    else $error("dynamic brake not entered");
  a_cs_entry: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_ON && cause_word != 8'h00 && mode_q[1]
    |=> cs_ramp_req && pwm_active)
    else $error("controlled stop not entered");
  a_cs_db_end: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_STOP && standstill && !expired && mode_q == MODE_CS_DB
    |=> state_q == S_DBRAKE)
    else $error("controlled stop did not brake");
  a_stop_pwm: assert property (@(posedge pclk) disable iff (!presetn)
    cs_ramp_req |-> pwm_active && !drive_enable && !dyn_brake_on)
    else $error("stop ramp outputs inconsistent");
  a_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_OFF |-> !pwm_active && !drive_enable)
    else $error("power stage active while off");
  a_reenable: assert property (@(posedge pclk) disable iff (!presetn)
    is_off && cause_word == 8'h00 |=> state_q == S_ON)
    else $error("drive not enabled with no cause");

  // Holding brake and emergency timeout supervision.
  a_brake_close: assert property (@(posedge pclk) disable iff (!presetn)
    brake_configured && state_q != S_ON && standstill |=> brake_close)
    else $error("holding brake not closed at low speed");
  a_brake_none: assert property (@(posedge pclk) disable iff (!presetn)
    !brake_configured |=> !brake_close)
    else $error("brake closed without a brake fitted");
  a_tmo_start: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_ON && cause_word != 8'h00 && tmo_q != 17'h00000
    |=> tmo_run_q && ms_q == 17'h00000)
    else $error("emergency timeout not started");
  a_tmo_off: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_ON && cause_word != 8'h00 && tmo_q == 17'h00000
    |=> !tmo_run_q)
    else $error("timeout ran although set to zero");
  a_emerg_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    emerg_q && !(wr && paddr == OFS_CTRL && pwdata[CTRL_CLR_BIT])
    |=> emerg_q)
    else $error("emergency fault lost without a clear");

  c_stop_to_brake: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == S_STOP ##1 state_q == S_DBRAKE);
  c_timeout: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(emerg_q));
  c_reenable: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == S_OFF ##1 state_q == S_ON);
  c_db_entry: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == S_ON ##1 state_q == S_DBRAKE);

endmodule
`default_nettype wire

//--- bench/motor_stage_model.sv
// Far-side model: motor speed that coasts down while the stage is off.
`timescale 1ns/1ps
`default_nettype none
module motor_stage_model #(
  parameter int VEL_W = 24
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Stage control and test knobs.
  input wire logic drive_enable,
  input wire logic stall,
  input wire logic [VEL_W-1:0] spin,
  // Speed fed back to the drive.
  output logic signed [VEL_W-1:0] vel_q
);
  localparam logic signed [VEL_W-1:0] STEP = 8;
  logic signed [VEL_W-1:0] vel_d;
  // A stalled motor keeps its speed, so the stop ramp ends only by the emergency timeout.
  always_comb begin
    vel_d = vel_q;
    if (drive_enable) begin
      vel_d = $signed(spin);
    end else if (!stall && vel_q > 0) begin
      vel_d = vel_q - STEP;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vel_q <= '0;
    end else begin
      vel_q <= vel_d;
    end
  end
endmodule
`default_nettype wire

//--- bench/drive_disable_control_bench.sv
// Self-checking bench of the drive disable controller.
`timescale 1ns/1ps
`default_nettype none
module drive_disable_control_bench;
  import drive_disable_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  cause_in_t cause_in = '0;
  logic home_done = 1'b0;
  logic stall = 1'b0;
  logic signed [23:0] vel;
  logic signed [15:0] cin = 16'h0;
  logic signed [31:0] pin = 32'h0;
  logic signed [15:0] cout;
  logic signed [31:0] pout;
  logic drive_enable, pwm_active, dyn_brake_on, cs_ramp_req, brake_close;
  logic [32:0] exp_q[$];
  int fails = 0;
  int cmp_count = 0;
  int seed = 43;
  always #4 pclk = ~pclk;
  drive_disable_control #(.CYC_PER_MS(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cause_in(cause_in),
    .brake_configured(1'b1), .home_done(home_done),
    .velocity_feedback(vel), .stop_velocity_threshold(24'h000010),
    .current_cmd_in(cin), .position_fb_in(pin),
    .drive_enable(drive_enable), .pwm_active(pwm_active),
    .dyn_brake_on(dyn_brake_on), .cs_ramp_req(cs_ramp_req),
    .brake_close(brake_close), .current_cmd_out(cout),
    .position_fb_out(pout));
  motor_stage_model #(.VEL_W(24)) motor (.pclk(pclk), .presetn(presetn),
    .drive_enable(drive_enable), .stall(stall), .spin(24'h0000C8),
    .vel_q(vel));
  task automatic check(string nm, logic [32:0] seen, logic [32:0] want);
    cmp_count++;
    if (seen !== want) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
    @(posedge pclk);
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic err);
    apb(1'b1, a, d, {err, 32'h0});
  endtask
  task automatic rd(logic [7:0] a, logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge pclk);
  endtask
  // Each completed transfer retires the oldest expected response.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spare transfer", 33'h0, 33'h1);
      end else if (pwrite) begin
        check("write status", {pslverr, 32'h0}, exp_q.pop_front());
      end else begin
        check("read word", {pslverr, prdata}, exp_q.pop_front());
      end
    end
  end
  initial begin
    tick(5000);
    fails++;
    tally_and_finish();
  end
  initial begin
    tick(8);
    presetn <= 1'b1;
    rd(OFS_MODE, 33'h0);
    rd(OFS_TMO, {16'h0, TMO_RESET_MS});
    rd(OFS_CAP, {25'h0, CAP_RESET});
    rd(OFS_CAUSE, 33'h1);
    rd(8'h20, 33'h1_0000_0000);
    wr(OFS_CAP, 32'h0, 1'b1);
    tick(1);
    home_done <= 1'b1;
    tick(1);
    home_done <= 1'b0;
    rd(OFS_MSTAT, 33'h1);
    wr(OFS_DIR, 32'h1, 1'b0);
    rd(OFS_MSTAT, 33'h0);
    tick(1);
    cin <= 16'($random(seed));
    pin <= $random(seed);
    tick(3);
    @(negedge pclk);
    check("current", 33'(cout), 33'(16'(-cin)));
    check("position", 33'(pout), 33'(32'(-pin)));
    wr(OFS_DIR, 32'h0, 1'b0);
    wr(OFS_CTRL, 32'h1, 1'b0);
    tick(3);
    @(negedge pclk);
    check("current", 33'(cout), 33'(cin));
    check("enable", 33'(drive_enable), 33'h1);
    rd(OFS_CAUSE, 33'h0);
    rd(OFS_STAT, 33'h1);
    wr(OFS_DIR, 32'h1, 1'b1);
    wr(OFS_MODE, 32'h3, 1'b1);
    rd(OFS_DIR, 33'h0);
    for (int i = 0; i < 7; i++) begin
      tick(1);
      cause_in <= cause_in_t'(7'h01 << i);
      tick(2);
      @(negedge pclk);
      check("enable", 33'(drive_enable), 33'(!CAP_RESET[i+1]));
      rd(OFS_CAUSE, 33'((9'h002 << i) & {1'b0, CAP_RESET}));
      cause_in <= '0;
      tick(4);
      @(negedge pclk);
      check("enable", 33'(drive_enable), 33'h1);
    end
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CTRL, 32'h2, 1'b0);
      tick(60);
      wr(OFS_MODE, 32'(m), 1'b0);
      rd(OFS_MODE, 33'(m));
      wr(OFS_CTRL, 32'h1, 1'b0);
      tick(4);
      wr(OFS_CTRL, 32'h2, 1'b0);
      tick(2);
      @(negedge pclk);
      check("pwm", 33'(pwm_active), 33'(m != 0));
      check("dyn brake", 33'(dyn_brake_on), 33'(m == 1));
      check("ramp", 33'(cs_ramp_req), 33'(m > 1));
      tick(60);
      rd(OFS_STAT, {29'h0, m[0], 3'h4});
    end
    wr(OFS_MODE, 32'h2, 1'b0);
    wr(OFS_TMO, 32'h2, 1'b0);
    wr(OFS_TMO, 32'h1D4C1, 1'b1);
    rd(OFS_TMO, 33'h2);
    wr(OFS_CTRL, 32'h1, 1'b0);
    tick(4);
    stall <= 1'b1;
    wr(OFS_CTRL, 32'h2, 1'b0);
    tick(20);
    @(negedge pclk);
    check("forced stop", 33'(cs_ramp_req), 33'h0);
    rd(OFS_STAT, 33'h2);
    rd(OFS_CAUSE, 33'h3);
    wr(OFS_CTRL, 32'h4, 1'b0);
    rd(OFS_STAT, 33'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
